// *** icb_bridge_cfg.sv ***
/*
  i2c control channel bridge configuration: control two, peer identity,
  target remap, sda output delay, bus watchdog with hung-bus recovery.
  assumes the local serial control target delivers register accesses and
  address bytes on the device clock; scl and sda inputs come from pins.
*/
// Functional notes
// - forward sequence error sets flag bit 7
// - bit 6 clears the flag, not self-clearing
// - sda output delay 250..400ns by code; rounded up to whole clocks, 300..400ns
// - bit 2 blocks remote writes to registers
// - watchdog 1s, or 50us with speedup
// - sda high and idle means bus free
// - sda low and idle: nine scl pulses
// - bit 0 disables watchdog entirely
// - hold clear: auto-load id, bits read-only
// - hold set: id writable and frozen
// - matched alias retargeted to slot address
// - alias registers hold local match addresses
// - forward only matched, pass-through enabled
`timescale 1ns/1ps
`default_nettype none
module icb_bridge_cfg
  import icb_pkg::*;
#(
  parameter int WD_SLOW_LIMIT = WD_SLOW_CYC
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire icb_reg_req_s reg_req,
  output logic [7:0]        reg_rdata,
  output logic              reg_wr_rejected,
  input  wire logic         seq_err_evt,
  input  wire logic         peer_id_valid,
  input  wire logic [6:0]   peer_id_in,
  input  wire logic         pass_through_en,
  input  wire logic         mreq_valid,
  input  wire logic [7:0]   mreq_byte,
  output logic              fwd_valid,
  output logic [7:0]        fwd_byte,
  input  wire logic         sda_drive_low,
  output logic              sda_out,
  output logic              sda_oe,
  input  wire logic         sda_in,
  input  wire logic         scl_in,
  output logic              scl_out,
  output logic              scl_oe,
  output logic              bus_free
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic int dly_cycles(input logic [1:0] code);
    case (code)
      2'h0:    dly_cycles = (SDA_DLY0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      2'h1:    dly_cycles = (SDA_DLY1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      2'h2:    dly_cycles = (SDA_DLY2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      default: dly_cycles = (SDA_DLY3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endcase
  endfunction

  function automatic logic wr_hit(input icb_reg_req_s r, input logic [7:0] ofs);
    wr_hit = r.wr && (r.addr == ofs);
  endfunction

  icb_state_s st_r;
  icb_state_s st_nxt;

  logic        wr_ok;
  logic        activity;
  logic [23:0] wd_limit;
  int          tap;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt   = st_r;
    wr_ok    = reg_req.wr && !(reg_req.remote && st_r.ctrl_two[B_WR_BLOCK]);
    activity = (st_r.scl_s2 != st_r.scl_p) || (st_r.sda_s2 != st_r.sda_p);
    wd_limit = st_r.ctrl_two[B_SPEEDUP] ? 24'(WD_FAST_CYC) : 24'(WD_SLOW_LIMIT);
    tap      = dly_cycles(st_r.ctrl_two[B_DLY_HI:B_DLY_LO]);

    st_nxt.wr_rejected = reg_req.wr && !wr_ok;

    if (wr_ok) begin
      if (wr_hit(reg_req, OFS_CTRL_TWO)) begin
        st_nxt.ctrl_two = (reg_req.wdata & CTRL_TWO_WMASK)
                        | (st_r.ctrl_two & ~CTRL_TWO_WMASK);
      end
      if (wr_hit(reg_req, OFS_PEER_ID)) begin
        st_nxt.peer_identity_value[B_HOLD_ID] = reg_req.wdata[B_HOLD_ID];
        if (st_r.peer_identity_value[B_HOLD_ID]) begin
          st_nxt.peer_identity_value[7:1] = reg_req.wdata[7:1];
        end
      end
      if (wr_hit(reg_req, OFS_TGT0)) begin
        st_nxt.tgt0 = {reg_req.wdata[7:1], 1'b0};
      end
      if (wr_hit(reg_req, OFS_TGT1)) begin
        st_nxt.tgt1 = {reg_req.wdata[7:1], 1'b0};
      end
      if (wr_hit(reg_req, OFS_MATCH0)) begin
        st_nxt.match0 = {reg_req.wdata[7:1], 1'b0};
      end
      if (wr_hit(reg_req, OFS_MATCH1)) begin
        st_nxt.match1 = {reg_req.wdata[7:1], 1'b0};
      end
    end

    // sequence error: set wins over clear
    if (seq_err_evt) begin
      st_nxt.ctrl_two[B_SEQ_ERR] = 1'b1;
    end else if (st_r.ctrl_two[B_SEQ_CLR]) begin
      st_nxt.ctrl_two[B_SEQ_ERR] = 1'b0;
    end

    // peer identity auto-load
    if (!st_r.peer_identity_value[B_HOLD_ID] && peer_id_valid) begin
      st_nxt.peer_identity_value[7:1] = peer_id_in;
    end

    // register read, one cycle latency
    case (reg_req.addr)
      OFS_CTRL_TWO: st_nxt.rdata = st_r.ctrl_two;
      OFS_PEER_ID:  st_nxt.rdata = st_r.peer_identity_value;
      OFS_TGT0:     st_nxt.rdata = st_r.tgt0;
      OFS_TGT1:     st_nxt.rdata = st_r.tgt1;
      OFS_MATCH0:   st_nxt.rdata = st_r.match0;
      OFS_MATCH1:   st_nxt.rdata = st_r.match1;
      default:      st_nxt.rdata = RST_REG;
    endcase

    // alias match and retarget
    st_nxt.fwd_valid = 1'b0;
    if (mreq_valid && pass_through_en) begin
      if (mreq_byte[7:1] == st_r.match0[7:1]) begin
        st_nxt.fwd_valid = 1'b1;
        st_nxt.fwd_byte  = {st_r.tgt0[7:1], mreq_byte[0]};
      end else if (mreq_byte[7:1] == st_r.match1[7:1]) begin
        st_nxt.fwd_valid = 1'b1;
        st_nxt.fwd_byte  = {st_r.tgt1[7:1], mreq_byte[0]};
      end
    end

    // sda output delay line
    st_nxt.sda_sh = {st_r.sda_sh[SDA_DLY_MAX-2:0], sda_drive_low};

    // pin synchronisers
    st_nxt.scl_s1 = scl_in;
    st_nxt.scl_s2 = st_r.scl_s1;
    st_nxt.sda_s1 = sda_in;
    st_nxt.sda_s2 = st_r.sda_s1;
    st_nxt.scl_p  = st_r.scl_s2;
    st_nxt.sda_p  = st_r.sda_s2;

    // ****************************************
    // bus watchdog
    // ****************************************
    if (st_r.ctrl_two[B_WD_OFF]) begin
      st_nxt.wd_st     = ICB_WATCH;
      st_nxt.wd_cnt    = 24'h000000;
      st_nxt.bus_free  = 1'b0;
      st_nxt.scl_low   = 1'b0;
      st_nxt.pulse_cnt = 4'h0;
      st_nxt.half_cnt  = 8'h00;
    end else begin
      case (st_r.wd_st)
        ICB_WATCH: begin
          if (activity) begin
            st_nxt.wd_cnt   = 24'h000000;
            st_nxt.bus_free = 1'b0;
          end else if (st_r.wd_cnt >= wd_limit - 24'h000001) begin
            if (st_r.sda_s2) begin
              st_nxt.bus_free = 1'b1;
            end else begin
              st_nxt.wd_st     = ICB_RECOVER;
              st_nxt.pulse_cnt = 4'h0;
              st_nxt.half_cnt  = 8'h00;
              st_nxt.scl_low   = 1'b1;
            end
          end else begin
            st_nxt.wd_cnt = st_r.wd_cnt + 24'h000001;
          end
        end
        ICB_RECOVER: begin
          st_nxt.wd_cnt = 24'h000000;
          if (st_r.half_cnt == 8'(SCL_HALF_CYC - 1)) begin
            st_nxt.half_cnt = 8'h00;
            st_nxt.scl_low  = !st_r.scl_low;
            if (!st_r.scl_low) begin
              st_nxt.pulse_cnt = st_r.pulse_cnt + 4'h1;
              st_nxt.scl_low   = 1'b1;
            end
            if (!st_r.scl_low && st_r.pulse_cnt == 4'(RECOVER_PULSES - 1)) begin
              st_nxt.scl_low = 1'b0;
              st_nxt.wd_st   = ICB_WATCH;
            end
          end else begin
            st_nxt.half_cnt = st_r.half_cnt + 8'h01;
          end
        end
        default: begin
          st_nxt.wd_st = ICB_WATCH;
        end
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata       = st_r.rdata;
  assign reg_wr_rejected = st_r.wr_rejected;
  assign fwd_valid       = st_r.fwd_valid;
  assign fwd_byte        = st_r.fwd_byte;
  assign sda_out         = 1'b0;
  assign sda_oe          = st_r.sda_sh[tap-1];
  assign scl_out         = 1'b0;
  assign scl_oe          = st_r.scl_low;
  assign bus_free        = st_r.bus_free;

endmodule
`default_nettype wire

// *** icb_bridge_cfg_checker.sv ***
/* assertions on the bridge config ports.
   assumes a bind onto icb_bridge_cfg. */
`timescale 1ns/1ps
`default_nettype none
module icb_bridge_cfg_checker
  import icb_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst_n,
  input wire icb_reg_req_s reg_req,
  input wire logic [7:0]   reg_rdata,
  input wire logic         reg_wr_rejected,
  input wire logic         seq_err_evt,
  input wire logic         pass_through_en,
  input wire logic         mreq_valid,
  input wire logic [7:0]   mreq_byte,
  input wire logic         fwd_valid,
  input wire logic [7:0]   fwd_byte,
  input wire logic         sda_drive_low,
  input wire logic         sda_out,
  input wire logic         sda_oe,
  input wire logic         sda_in,
  input wire logic         scl_oe,
  input wire logic         bus_free
);
  // ****
  // scl low time counter
  // ****
  logic [7:0] hi_cnt_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hi_cnt_r <= 8'h00;
    else hi_cnt_r <= scl_oe ? hi_cnt_r + 8'h01 : 8'h00;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****
  // properties
  // ****
  a_seq_set: assert property (seq_err_evt ##1 reg_req.addr == OFS_CTRL_TWO |=> reg_rdata[7])
    else $error("seq flag not set");
  a_seq_clr: assert property (reg_rdata[6] && $past(reg_req.addr) == OFS_CTRL_TWO
    && reg_req.addr == OFS_CTRL_TWO && !$past(seq_err_evt) |=> !reg_rdata[7])
    else $error("seq flag not cleared");
  a_rej_remote: assert property (reg_wr_rejected |-> $past(reg_req.wr) && $past(reg_req.remote))
    else $error("reject without remote write");
  a_rej_local: assert property (reg_req.wr && !reg_req.remote |=> !reg_wr_rejected)
    else $error("local write rejected");
  a_fwd_en: assert property (fwd_valid |-> $past(mreq_valid) && $past(pass_through_en))
    else $error("forward without request");
  a_fwd_rw: assert property (fwd_valid |-> fwd_byte[0] == $past(mreq_byte[0]))
    else $error("direction bit changed");
  a_sda_dly: assert property ($rose(sda_oe) |-> $past(sda_drive_low, 3) && !sda_out)
    else $error("sda pulled too early");
  a_scl_low: assert property ($fell(scl_oe) |-> hi_cnt_r == 8'h32)
    else $error("scl low time wrong");
  a_free_idle: assert property ($rose(bus_free) |-> sda_in && $past(sda_in, 4) && !scl_oe)
    else $error("bus free while busy");
  cover property (fwd_valid);
  cover property (reg_wr_rejected);
  cover property ($fell(scl_oe));
endmodule
bind icb_bridge_cfg icb_bridge_cfg_checker chk_u (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .reg_wr_rejected(reg_wr_rejected), .seq_err_evt(seq_err_evt),
  .pass_through_en(pass_through_en), .mreq_valid(mreq_valid), .mreq_byte(mreq_byte),
  .fwd_valid(fwd_valid), .fwd_byte(fwd_byte), .sda_drive_low(sda_drive_low),
  .sda_out(sda_out), .sda_oe(sda_oe), .sda_in(sda_in), .scl_oe(scl_oe), .bus_free(bus_free));
`default_nettype wire

// *** icb_peer_model.sv ***
/* bus wires with pull-ups and the peer_identity_value source.
   assumes enables high while a party pulls low. */
`timescale 1ns/1ps
`default_nettype none
module icb_peer_model (
  input  wire logic       clk,
  input  wire logic       sda_oe,
  input  wire logic       scl_oe,
  input  wire logic       sda_hold_low,
  input  wire logic       id_send,
  input  wire logic [6:0] id_val,
  output logic            sda_in,
  output logic            scl_in,
  output var logic        peer_id_valid,
  output var logic [6:0]  peer_id_in
);
  assign sda_in = ~(sda_oe | sda_hold_low);
  assign scl_in = ~scl_oe;
  initial begin
    peer_id_valid = 1'b0;
    peer_id_in = 7'h15;
  end
  // id shown one cycle, else a moving pattern
  always @(posedge clk) begin
    peer_id_valid <= id_send;
    peer_id_in <= id_send ? id_val : ~peer_id_in;
  end
endmodule
`default_nettype wire

// *** icb_pkg.sv ***
/*
  package of the i2c control channel bridge configuration block:
  register offsets, field positions, reset values, timing constants.
  assumes a 10 MHz device clock.
*/
`default_nettype none
package icb_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int WD_SLOW_NS    = 1000000000;
  localparam int WD_FAST_NS    = 50000;
  localparam int WD_SLOW_CYC   = WD_SLOW_NS / CLK_PERIOD_NS;
  localparam int WD_FAST_CYC   = WD_FAST_NS / CLK_PERIOD_NS;
  localparam int SCL_HALF_NS   = 5000;
  localparam int SCL_HALF_CYC  = SCL_HALF_NS / CLK_PERIOD_NS;
  localparam int RECOVER_PULSES = 9;
  localparam int SDA_DLY0_NS   = 250;
  localparam int SDA_DLY1_NS   = 300;
  localparam int SDA_DLY2_NS   = 350;
  localparam int SDA_DLY3_NS   = 400;
  localparam int SDA_DLY_MAX   = (SDA_DLY3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // register offsets and reset values
  // ****************************************
  localparam logic [7:0] OFS_CTRL_TWO  = 8'h06;
  localparam logic [7:0] OFS_PEER_ID   = 8'h07;
  localparam logic [7:0] OFS_TGT0      = 8'h08;
  localparam logic [7:0] OFS_TGT1      = 8'h09;
  localparam logic [7:0] OFS_MATCH0    = 8'h10;
  localparam logic [7:0] OFS_MATCH1    = 8'h11;
  localparam logic [7:0] RST_REG       = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int B_SEQ_ERR   = 7;
  localparam int B_SEQ_CLR   = 6;
  localparam int B_DLY_HI    = 4;
  localparam int B_DLY_LO    = 3;
  localparam int B_WR_BLOCK  = 2;
  localparam int B_SPEEDUP   = 1;
  localparam int B_WD_OFF    = 0;
  localparam int B_HOLD_ID   = 0;
  localparam logic [7:0] CTRL_TWO_WMASK = 8'h5F;

  typedef enum logic {ICB_WATCH, ICB_RECOVER} icb_wd_e;

  typedef struct packed {
    logic [7:0] ctrl_two;
    logic [7:0] peer_identity_value;
    logic [7:0] tgt0;
    logic [7:0] tgt1;
    logic [7:0] match0;
    logic [7:0] match1;
    logic [7:0] rdata;
    logic [SDA_DLY_MAX-1:0] sda_sh;
    logic       scl_s1;
    logic       scl_s2;
    logic       sda_s1;
    logic       sda_s2;
    logic       scl_p;
    logic       sda_p;
    logic [23:0] wd_cnt;
    icb_wd_e    wd_st;
    logic [3:0] pulse_cnt;
    logic [7:0] half_cnt;
    logic       scl_low;
    logic       bus_free;
    logic       fwd_valid;
    logic [7:0] fwd_byte;
    logic       wr_rejected;
  } icb_state_s;

  // pin synchronisers start at the idle high level, so no false edge
  localparam icb_state_s ST_RST = '{wd_st:   ICB_WATCH,
                                    scl_s1:  1'b1,
                                    scl_s2:  1'b1,
                                    sda_s1:  1'b1,
                                    sda_s2:  1'b1,
                                    scl_p:   1'b1,
                                    sda_p:   1'b1,
                                    default: '0};

  typedef struct packed {
    logic       wr;
    logic       remote;
    logic [7:0] addr;
    logic [7:0] wdata;
  } icb_reg_req_s;
endpackage
`default_nettype wire

// *** test_icb_bridge_cfg.sv ***
/* self-checking bench of icb_bridge_cfg.
   assumes package, design, checker and peer model. */
`timescale 1ns/1ps
`default_nettype none
module test_icb_bridge_cfg;
  import icb_pkg::*;
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
  logic clk, rst_n, reg_wr_rejected, seq_err_evt, peer_id_valid, pass_through_en, mreq_valid;
  logic fwd_valid, sda_drive_low, sda_out, sda_oe, sda_in, scl_in, scl_out, scl_oe, bus_free;
  logic sda_hold_low, id_send, rd_now, rd_d, prev;
  icb_reg_req_s reg_req;
  logic [6:0] peer_id_in, id_val;
  logic [7:0] reg_rdata, fwd_byte, mreq_byte, exp_b, t0, t1, m0, m1;
  logic [7:0] rd_q[$], fwd_q[$];
  logic [7:0] ofs[7] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h10, 8'h11, 8'h3C};
  int error_cnt, num_checks, n, k;
  icb_bridge_cfg #(.WD_SLOW_LIMIT(200)) dut_u (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_wr_rejected(reg_wr_rejected), .seq_err_evt(seq_err_evt),
    .peer_id_valid(peer_id_valid), .peer_id_in(peer_id_in), .pass_through_en(pass_through_en),
    .mreq_valid(mreq_valid), .mreq_byte(mreq_byte), .fwd_valid(fwd_valid), .fwd_byte(fwd_byte),
    .sda_drive_low(sda_drive_low), .sda_out(sda_out), .sda_oe(sda_oe), .sda_in(sda_in),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .bus_free(bus_free));
  icb_peer_model peer_u (.clk(clk), .sda_oe(sda_oe), .scl_oe(scl_oe), .sda_hold_low(sda_hold_low),
    .id_send(id_send), .id_val(id_val), .sda_in(sda_in), .scl_in(scl_in),
    .peer_id_valid(peer_id_valid), .peer_id_in(peer_id_in));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task step;
    @(posedge clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d, input logic rem);
    reg_req = '{1'b1, rem, a, d};
    step;
    reg_req.wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    reg_req.addr = a;
    rd_now = 1'b1;
    rd_q.push_back(e);
    step;
    rd_now = 1'b0;
  endtask
  task finish_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ****
  // result monitor
  // ****
  always @(posedge clk) begin
    rd_d <= rd_now;
  end
  // outputs compared mid-cycle, where they are settled
  always @(negedge clk) begin
    if (rd_d) begin
      exp_b = rd_q.pop_front();
      `CHK("rdata", exp_b, reg_rdata)
    end
    if (fwd_valid) begin
      exp_b = (fwd_q.size() > 0) ? fwd_q.pop_front() : 8'hXX;
      `CHK("fwd_byte", exp_b, fwd_byte)
    end
  end
  initial begin
    #(100 * 20000);
    error_cnt++;
    finish_test;
  end
  // ****
  // scenarios
  // ****
  initial begin
    void'($urandom(32'h3B2D));
    {seq_err_evt, pass_through_en, mreq_valid, sda_drive_low, sda_hold_low, id_send} = '0;
    {rd_now, rd_d, mreq_byte, id_val} = '0;
    reg_req = '0;
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    for (n = 0; n < 400 && !bus_free; n++) step;
    `CHK("free_time", 1'b1, n > 190 && n < 215)
    foreach (ofs[i]) rd(ofs[i], RST_REG);
    wr(OFS_CTRL_TWO, 8'hFF, 1'b0);
    rd(OFS_CTRL_TWO, 8'h5F);
    wr(OFS_CTRL_TWO, 8'h00, 1'b0);
    seq_err_evt = 1'b1;
    step;
    seq_err_evt = 1'b0;
    rd(OFS_CTRL_TWO, 8'h80);
    wr(OFS_CTRL_TWO, 8'h40, 1'b0);
    // flag still set in the cycle the clear bit lands
    rd(OFS_CTRL_TWO, 8'hC0);
    rd(OFS_CTRL_TWO, 8'h40);
    id_val = 7'($urandom);
    for (k = 0; k < 2; k++) begin
      id_send = 1'b1;
      step;
      id_send = 1'b0;
      id_val = ~id_val;
      step;
      rd(OFS_PEER_ID, (k == 0) ? {~id_val, 1'b0} : {id_val, 1'b1});
      wr(OFS_PEER_ID, {id_val ^ 7'h01, 1'b1}, 1'b0);
    end
    rd(OFS_PEER_ID, {id_val ^ 7'h01, 1'b1});
    t0 = 8'($urandom);
    t1 = 8'($urandom);
    m0 = 8'($urandom);
    m1 = m0 ^ 8'h02;
    wr(OFS_TGT0, t0, 1'b0);
    step;
    wr(OFS_TGT1, t1, 1'b0);
    step;
    wr(OFS_MATCH0, m0, 1'b0);
    step;
    wr(OFS_MATCH1, m1, 1'b0);
    rd(OFS_TGT0, {t0[7:1], 1'b0});
    for (k = 0; k < 6; k++) begin
      pass_through_en = (k != 5);
      mreq_byte = {(k == 4) ? m0[7:1] ^ 7'h02 : (k inside {2, 3}) ? m1[7:1] : m0[7:1], k[0]};
      if (k < 4) fwd_q.push_back({(k < 2) ? t0[7:1] : t1[7:1], k[0]});
      mreq_valid = 1'b1;
      step;
    end
    mreq_valid = 1'b0;
    step;
    step;
    `CHK("fwd_left", 0, fwd_q.size())
    wr(OFS_CTRL_TWO, 8'h04, 1'b0);
    for (k = 0; k < 2; k++) begin
      wr(OFS_TGT0, 8'h66, k == 0);
      `CHK("reject", k == 0, reg_wr_rejected)
      rd(OFS_TGT0, (k == 0) ? {t0[7:1], 1'b0} : 8'h66);
    end
    for (k = 0; k < 4; k++) begin
      wr(OFS_CTRL_TWO, 8'(k << 3), 1'b0);
      sda_drive_low = 1'b1;
      for (n = 0; n < 10 && !sda_oe; n++) step;
      `CHK("sda_delay", (k < 2) ? 3 : 4, n)
      sda_drive_low = 1'b0;
      repeat (6) step;
    end
    wr(OFS_CTRL_TWO, 8'h02, 1'b0);
    sda_hold_low = 1'b1;
    for (n = 0; n < 700 && !scl_oe; n++) step;
    `CHK("wd_fast", 1'b1, n > 494 && n < 520)
    k = 1;
    for (n = 0; n < 1100; n++) begin
      prev = scl_oe;
      step;
      k += (scl_oe && !prev);
    end
    `CHK("scl_pulses", 9, k)
    wr(OFS_CTRL_TWO, 8'h01, 1'b0);
    k = 0;
    repeat (1200) begin
      step;
      k += (scl_oe || bus_free);
    end
    `CHK("wd_off", 0, k)
    `CHK("pins_low", 2'b00, {sda_out, scl_out})
    sda_hold_low = 1'b0;
    finish_test;
  end
endmodule
`default_nettype wire
